// >>> clk_ctrl_defines.vh
// Register map, field positions, reset values and timing constants of the clock controller
`ifndef CLK_CTRL_DEFINES_VH
`define CLK_CTRL_DEFINES_VH

// Byte offsets on the register bus
`define OFS_CLK_CTRL   8'h00
`define OFS_PLL_DIV    8'h04
`define OFS_CLK_DIV    8'h08
`define OFS_STATUS     8'h0c
`define OFS_PLL_FREQ   8'h10

// Control register fields
`define CTRL_ROOT_MSB  1
`define CTRL_ROOT_LSB  0
`define CTRL_FAST_PLL  2
`define CTRL_PLL_EN    3
`define CTRL_DEEP      4

// Root source codes
`define ROOT_REF       2'h0
`define ROOT_RING      2'h1
`define ROOT_XTAL      2'h2
`define ROOT_EXT       2'h3

// PLL divider register fields
`define DIV_IN_MSB     4
`define DIV_IN_LSB     0
`define DIV_FB_MSB     13
`define DIV_FB_LSB     5
`define DIV_OUT_MSB    18
`define DIV_OUT_LSB    14

// Bus and auxiliary clock divider fields
`define CDIV_H_MSB     3
`define CDIV_H_LSB     0
`define CDIV_A_MSB     7
`define CDIV_A_LSB     4

// Reset values: reference root, fast clock on root, PLL off, 10 MHz divider set
`define RST_CLK_CTRL   32'h0000_0000
`define RST_PLL_DIV    32'h0000_4100
`define RST_CLK_DIV    32'h0000_0000

// PLL arithmetic
`define REF_KHZ        4000
`define PLL_FIXED_DIV  2
`define FB_CODE_OFS    2
`define IN_CODE_OFS    2

// Lock wait, counted in reference clock periods, rounded up
`define LOCK_TIME_US   500
`define LOCK_CYC       ((`LOCK_TIME_US * `REF_KHZ + 999) / 1000)

`endif

// >>> clk_glitch_free_mux.v
// Glitch-free clock select over sampled clock levels
`timescale 1ns/100ps
`default_nettype none
module clk_glitch_free_mux #(
    parameter N  = 4,
    parameter SW = 2
) (
    input  wire          clk_i,    // Sampling clock
    input  wire          rst_b_i,  // Synchronous reset, active low
    input  wire [N-1:0]  src_i,    // Sampled source clock levels
    input  wire [SW-1:0] sel_i,    // Requested source
    output reg           clk_o,    // Selected clock level
    output reg  [SW-1:0] cur_o,    // Source actually driving
    output reg           busy_o    // Handover in progress
);
    localparam ST_RUN  = 2'h0;
    localparam ST_DROP = 2'h1;
    localparam ST_PICK = 2'h2;

    reg [1:0] state_q;
    reg       on_q;

    // Drop the old source only while it sits low, then take the new one only once it sits low, so no short pulse escapes
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q <= ST_RUN;
            on_q    <= 1'b1;
            cur_o   <= {SW{1'b0}};
            clk_o   <= 1'b0;
            busy_o  <= 1'b0;
        end else begin
            clk_o  <= on_q & src_i[cur_o]; // RULE21
            busy_o <= (state_q != ST_RUN) || (sel_i != cur_o);
            case (state_q)
                ST_RUN: begin
                    if (sel_i != cur_o) begin
                        state_q <= ST_DROP;
                    end
                end
                ST_DROP: begin
                    if (!src_i[cur_o]) begin
                        on_q    <= 1'b0; // RULE21
                        cur_o   <= sel_i;
                        state_q <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    if (!src_i[cur_o]) begin
                        on_q    <= 1'b1; // RULE21
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> clk_ctrl_top.v
// Clock controller: source and PLL selection, lock wait, clock dividers and sleep gating
//
// Behaviour
// RULE1 - PLL reference is only the 4 MHz trimmed reference oscillator.
// RULE2 - PLL output equals input times multiplier over input, output divider and two.
// RULE3 - Input divider 2..33, multiplier 2..513, output divider 1..16.
// RULE4 - Multiplier code is value minus two; output divider code equals divisor.
// RULE5 - Input divider code is divisor minus two.
// RULE6 - Software keeps reference over input divider within 1 to 25 MHz.
// RULE7 - Software keeps output frequency times output divider within 100 to 250 MHz.
// RULE8 - Software waits 500 us for lock after divider writes.
// RULE9 - Software bring-up order: reference root, ring off, dividers, wait, select PLL.
// RULE10 - Selecting the PLL makes it drive the fast system clock.
// RULE11 - PLL disable stops its output at once.
// RULE12 - Software moves the fast clock to a running root before disabling the PLL.
// RULE13 - Ordinary sleep halts the processor; any enabled interrupt wakes it.
// RULE14 - Deep sleep gates the auxiliary, bus/core and part of the fast clock.
// RULE15 - In deep sleep only real-time timer, watchdog and GPIO can wake.
// RULE16 - Timer or watchdog wake restores gated clocks and interrupts the processor.
// RULE17 - Fast system clock selects root clock or PLL output by register.
// RULE18 - Root clock selects among reference, ring, crystal and external input.
// RULE19 - Bus/core and auxiliary clocks each divide the fast clock programmably.
// RULE20 - Software never selects a stopped source.
// RULE21 - Clock muxes switch without glitches.
// RULE22 - PLL output stays gated until the reference-counted lock timer expires.
`timescale 1ns/100ps
`default_nettype none
`include "clk_ctrl_defines.vh"
module clk_ctrl_top #(
    parameter LOCK_CYCLES = `LOCK_CYC,
    parameter DIV_W       = 4
) (
    input  wire        clk_i,               // 50 MHz controller clock
    input  wire        rst_b_i,             // Synchronous reset, active low
    input  wire        hsel_i,              // AHB slave select
    input  wire [31:0] haddr_i,             // AHB address
    input  wire [1:0]  htrans_i,            // AHB transfer type
    input  wire        hwrite_i,            // AHB write
    input  wire [2:0]  hsize_i,             // AHB size, word only
    input  wire [31:0] hwdata_i,            // AHB write data
    input  wire        hready_i,            // AHB bus ready
    output reg         hreadyout_o,         // AHB slave ready
    output reg         hresp_o,             // AHB response, always OKAY
    output reg  [31:0] hrdata_o,            // AHB read data
    input  wire        ref_osc_4m_i,        // Reference oscillator level
    input  wire        ring_osc_i,          // Ring oscillator level
    input  wire        xtal_clk_i,          // Crystal driver level
    input  wire        ext_clk_in_i,        // External clock level
    input  wire        pll_out_clk_i,       // Raw PLL output level
    output reg         pll_ref_clk_o,       // Reference fed to the PLL
    output reg         pll_en_o,            // PLL enable
    output reg  [4:0]  pll_in_divider_o,    // Input divider code
    output reg  [8:0]  pll_fb_multiplier_o, // Feedback multiplier code
    output reg  [4:0]  pll_out_divider_o,   // Output divider code
    output reg         root_clk_o,          // Root source clock
    output reg         fast_sys_clk_o,      // Fast system clock, ungated
    output reg         fast_sys_clk_gated_o,        // Fast clock branch stopped in deep sleep
    output reg         hclk_o,              // Bus/core clock
    output reg         aclk_o,              // Auxiliary clock
    input  wire        wfi_i,               // Processor enters sleep, pulse
    input  wire        irq_pending_i,       // Any enabled interrupt pending
    input  wire        wake_rtc_i,          // Real-time timer wake
    input  wire        wake_wdt_i,          // Watchdog wake
    input  wire        wake_gpio_i,         // GPIO wake
    output reg         cpu_halt_o,          // Processor halted
    output reg         wake_irq_o           // Wake interrupt, one-cycle pulse
);
    localparam PW_AWAKE = 2'h0;
    localparam PW_SLEEP = 2'h1;
    localparam PW_DEEP  = 2'h2;

    reg  [31:0] ctrl_q;
    reg  [31:0] pdiv_q;
    reg  [31:0] cdiv_q;
    reg         wr_pend_q;
    reg  [7:0]  wr_addr_q;
    reg         ref_prev_q;
    reg  [11:0] lock_cnt_q;
    reg         locked_q;
    reg  [31:0] freq_q;
    reg  [1:0]  pw_q;
    reg         fast_prev_q;
    wire        root_clk;
    wire [1:0]  root_cur;
    wire        root_busy;
    wire        fast_clk;
    wire [0:0]  fast_cur;
    wire        fast_busy;
    wire        pll_gated;
    wire        addr_ok;
    wire        fast_rise;
    wire        deep;
    wire [1:0]  div_clk;
    wire        pll_div_wr;

    function [31:0] read_reg;
        input [7:0] a;
        begin
            case (a)
                `OFS_CLK_CTRL: read_reg = ctrl_q;
                `OFS_PLL_DIV:  read_reg = pdiv_q;
                `OFS_CLK_DIV:  read_reg = cdiv_q;
                `OFS_STATUS:   read_reg = {24'h0, fast_busy, root_busy, (pw_q == PW_DEEP),
                                           root_cur, fast_cur[0], pll_gated, locked_q};
                `OFS_PLL_FREQ: read_reg = freq_q;
                default:       read_reg = 32'h0;
            endcase
        end
    endfunction

    // Wake decode; GPIO wakes the core but raises no wake interrupt
    function wake_hit;
        input irq_only;
        input rtc;
        input wdt;
        input gpio;
        begin
            wake_hit = rtc | wdt | (gpio & ~irq_only);
        end
    endfunction

    // Stored codes sit below the real ratio; widen before the offset is added
    function [31:0] code_ratio;
        input [8:0]  code;
        input [31:0] ofs;
        begin
            code_ratio = {23'h0, code} + ofs;
        end
    endfunction

    // An output code of zero would divide by zero, so it counts as one
    function [31:0] out_ratio;
        input [4:0] code;
        begin
            out_ratio = (code == 5'h0) ? 32'h1 : {27'h0, code};
        end
    endfunction

    // Bus slave: zero wait states, writes land at the end of the data phase
    assign addr_ok = hsel_i & htrans_i[1] & hready_i;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            hrdata_o    <= 32'h0;
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h0;
            ctrl_q      <= `RST_CLK_CTRL;
            pdiv_q      <= `RST_PLL_DIV;
            cdiv_q      <= `RST_CLK_DIV;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            wr_pend_q   <= addr_ok & hwrite_i;
            if (addr_ok) begin
                wr_addr_q <= {haddr_i[7:2], 2'b00};
            end
            if (addr_ok & !hwrite_i) begin
                hrdata_o <= read_reg({haddr_i[7:2], 2'b00});
            end
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `OFS_CLK_CTRL: ctrl_q <= {27'h0, hwdata_i[4:0]};
                    `OFS_PLL_DIV:  pdiv_q <= {13'h0, hwdata_i[18:0]};
                    `OFS_CLK_DIV:  cdiv_q <= {24'h0, hwdata_i[7:0]};
                    default:       ctrl_q <= ctrl_q;
                endcase
            end
        end
    end

    assign pll_div_wr = wr_pend_q && (wr_addr_q == `OFS_PLL_DIV);

    // Divider codes go straight to the analog PLL; the field coding is the PLL's own
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            pll_ref_clk_o       <= 1'b0;
            pll_en_o            <= 1'b0;
            pll_in_divider_o    <= 5'h0;
            pll_fb_multiplier_o <= 9'h0;
            pll_out_divider_o   <= 5'h0;
        end else begin
            pll_ref_clk_o       <= ref_osc_4m_i; // RULE1
            pll_en_o            <= ctrl_q[`CTRL_PLL_EN];
            pll_in_divider_o    <= pdiv_q[`DIV_IN_MSB:`DIV_IN_LSB]; // RULE5
            pll_fb_multiplier_o <= pdiv_q[`DIV_FB_MSB:`DIV_FB_LSB]; // RULE4
            pll_out_divider_o   <= pdiv_q[`DIV_OUT_MSB:`DIV_OUT_LSB]; // RULE4
        end
    end

    // Expected output frequency in kHz
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            freq_q <= 32'h0;
        end else begin
            freq_q <= (`REF_KHZ * code_ratio(pdiv_q[`DIV_FB_MSB:`DIV_FB_LSB], `FB_CODE_OFS))
                      / (code_ratio({4'h0, pdiv_q[`DIV_IN_MSB:`DIV_IN_LSB]}, `IN_CODE_OFS)
                      * out_ratio(pdiv_q[`DIV_OUT_MSB:`DIV_OUT_LSB])
                      * `PLL_FIXED_DIV); // RULE2 RULE3
        end
    end

    // Lock wait on reference edges; restarted by divider writes and by disable
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ref_prev_q <= 1'b0;
            lock_cnt_q <= LOCK_CYCLES[11:0];
            locked_q   <= 1'b0;
        end else begin
            ref_prev_q <= ref_osc_4m_i;
            if (pll_div_wr || !ctrl_q[`CTRL_PLL_EN]) begin
                lock_cnt_q <= LOCK_CYCLES[11:0]; // RULE22
                locked_q   <= 1'b0; // RULE11
            end else if (lock_cnt_q == 12'h0) begin
                locked_q <= 1'b1; // RULE22
            end else if (ref_osc_4m_i && !ref_prev_q) begin
                lock_cnt_q <= lock_cnt_q - 12'h1; // RULE22
            end
        end
    end

    // Disable gates the PLL without waiting on any register stage
    assign pll_gated = pll_out_clk_i & ctrl_q[`CTRL_PLL_EN] & locked_q; // RULE11 RULE22

    clk_glitch_free_mux #(
        .N  (4),
        .SW (2)
    ) u_root_mux (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .src_i   ({ext_clk_in_i, xtal_clk_i, ring_osc_i, ref_osc_4m_i}), // RULE18
        .sel_i   (ctrl_q[`CTRL_ROOT_MSB:`CTRL_ROOT_LSB]),
        .clk_o   (root_clk),
        .cur_o   (root_cur),
        .busy_o  (root_busy)
    );

    clk_glitch_free_mux #(
        .N  (2),
        .SW (1)
    ) u_fast_mux (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .src_i   ({pll_gated, root_clk}), // RULE17
        .sel_i   (ctrl_q[`CTRL_FAST_PLL]), // RULE10
        .clk_o   (fast_clk),
        .cur_o   (fast_cur),
        .busy_o  (fast_busy)
    );

    // Sleep control
    assign deep = (pw_q == PW_DEEP);

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            pw_q       <= PW_AWAKE;
            wake_irq_o <= 1'b0;
        end else begin
            wake_irq_o <= 1'b0;
            case (pw_q)
                PW_AWAKE: begin
                    if (wfi_i) begin
                        pw_q <= ctrl_q[`CTRL_DEEP] ? PW_DEEP : PW_SLEEP;
                    end
                end
                PW_SLEEP: begin
                    if (irq_pending_i) begin
                        pw_q <= PW_AWAKE; // RULE13
                    end
                end
                PW_DEEP: begin
                    if (wake_hit(1'b0, wake_rtc_i, wake_wdt_i, wake_gpio_i)) begin
                        pw_q <= PW_AWAKE; // RULE15
                    end
                    if (wake_hit(1'b1, wake_rtc_i, wake_wdt_i, wake_gpio_i)) begin
                        wake_irq_o <= 1'b1; // RULE16
                    end
                end
                default: begin
                    pw_q <= PW_AWAKE;
                end
            endcase
        end
    end

    // Dividers count fast clock rising edges; code 0 passes the fast clock through
    assign fast_rise = fast_clk & ~fast_prev_q;

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            fast_prev_q <= 1'b0;
        end else begin
            fast_prev_q <= fast_clk;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_div
            reg  [DIV_W-1:0] cnt_q;
            reg              tog_q;
            wire [DIV_W-1:0] code;
            assign code = cdiv_q[g*4 +: DIV_W];
            always @(posedge clk_i) begin
                if (!rst_b_i) begin
                    cnt_q <= {DIV_W{1'b0}};
                    tog_q <= 1'b0;
                end else if (fast_rise) begin
                    if (cnt_q + 1'b1 >= code) begin
                        cnt_q <= {DIV_W{1'b0}};
                        tog_q <= ~tog_q; // RULE19
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
            end
            // Pass-through form adds no lag; fast_clk is already a flop output, so every output stays on a flop
            assign div_clk[g] = (code == {DIV_W{1'b0}}) ? fast_clk : tog_q;
        end
    endgenerate

    // Clock outputs; the root clock keeps running so sleep-time timers stay alive
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            root_clk_o     <= 1'b0;
            fast_sys_clk_o <= 1'b0;
            fast_sys_clk_gated_o   <= 1'b0;
            hclk_o         <= 1'b0;
            aclk_o         <= 1'b0;
            cpu_halt_o     <= 1'b0;
        end else begin
            root_clk_o     <= root_clk;
            fast_sys_clk_o <= fast_clk; // RULE10
            fast_sys_clk_gated_o   <= fast_clk & ~deep; // RULE14
            hclk_o         <= div_clk[0] & ~deep; // RULE14 RULE16
            aclk_o         <= div_clk[1] & ~deep; // RULE14 RULE16
            cpu_halt_o     <= (pw_q != PW_AWAKE); // RULE13
        end
    end
endmodule
`default_nettype wire

// >>> clk_ctrl_props.sv
// Concurrent checks on the clock controller ports
`timescale 1ns/100ps
`default_nettype none
module clk_ctrl_props (
    input wire logic        clk_i,          // Controller clock
    input wire logic        rst_b_i,        // Reset, active low
    input wire logic        hsel_i,         // Bus select
    input wire logic [1:0]  htrans_i,       // Transfer type
    input wire logic        hwrite_i,       // Write
    input wire logic        hready_i,       // Bus ready
    input wire logic        hreadyout_o,    // Slave ready
    input wire logic        hresp_o,        // Response
    input wire logic [31:0] hrdata_o,       // Read data
    input wire logic        ref_osc_4m_i,   // Reference level
    input wire logic        pll_ref_clk_o,  // PLL reference
    input wire logic        root_clk_o,     // Root clock
    input wire logic        wfi_i,          // Sleep request
    input wire logic        wake_rtc_i,     // Timer wake
    input wire logic        wake_wdt_i,     // Watchdog wake
    input wire logic        cpu_halt_o,     // Halted
    input wire logic        wake_irq_o      // Wake interrupt
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire rd_take = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    wire dwake   = wake_rtc_i || wake_wdt_i;
    sequence s_wfi_awake;
        wfi_i && !cpu_halt_o && !wake_irq_o;
    endsequence
    // Registered wake may land one or two edges after its cause
    sequence s_wake_seen;
        $past(dwake) || $past(dwake, 2);
    endsequence
    a_resp_okay: assert property (!hresp_o && hreadyout_o)
        else $error("bus slave not ready or not okay");
    a_rdata_hold: assert property (!rd_take |=> $stable(hrdata_o))
        else $error("read data moved without a read");
    a_ref_only: assert property ($past(rst_b_i) |-> pll_ref_clk_o == $past(ref_osc_4m_i))
        else $error("pll reference is not the reference oscillator");
    // Sources run at least two cycles a half period, so one-cycle levels are glitches
    a_root_clean: assert property ($changed(root_clk_o) |=> $stable(root_clk_o))
        else $error("root clock glitch");
    a_halt_wfi: assert property (s_wfi_awake |-> ##[1:3] cpu_halt_o)
        else $error("no halt after sleep request");
    a_wake_cause: assert property (wake_irq_o |-> s_wake_seen)
        else $error("wake interrupt without timer or watchdog");
    a_irq_pulse: assert property (wake_irq_o |=> !wake_irq_o)
        else $error("wake interrupt longer than one cycle");
    a_wake_run: assert property (wake_irq_o |-> ##[0:2] !cpu_halt_o)
        else $error("processor still halted after wake");
endmodule
bind clk_ctrl_top clk_ctrl_props u_props (.clk_i, .rst_b_i, .hsel_i, .htrans_i, .hwrite_i,
    .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .ref_osc_4m_i, .pll_ref_clk_o,
    .root_clk_o, .wfi_i, .wake_rtc_i, .wake_wdt_i, .cpu_halt_o, .wake_irq_o);
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the clock controller
`timescale 1ns/100ps
`default_nettype none
`include "clk_ctrl_defines.vh"
module testbench;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic        hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [4:0]  srcs = 5'h0; // ref, ring, xtal, ext, pll
    logic        wfi_i = 1'b0;
    logic        irq_pending_i = 1'b0;
    logic [2:0]  wake = 3'h0; // rtc, wdt, gpio
    int          mismatches = 0;
    int          n_tests = 0;
    wire  [31:0] hrdata_o;
    wire  [4:0]  pll_in_divider_o, pll_out_divider_o;
    wire  [8:0]  pll_fb_multiplier_o;
    wire         hreadyout_o, hresp_o, pll_ref_clk_o, pll_en_o, root_clk_o, fast_sys_clk_o;
    wire         fast_sys_clk_gated_o, hclk_o, aclk_o, cpu_halt_o, wake_irq_o;
    wire  [5:0]  mon = {hclk_o | aclk_o | fast_sys_clk_gated_o, aclk_o, hclk_o, fast_sys_clk_gated_o,
                        fast_sys_clk_o, root_clk_o};
    clk_ctrl_top #(.LOCK_CYCLES(8), .DIV_W(4)) dut (.clk_i, .rst_b_i, .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
        .hreadyout_o, .hresp_o, .hrdata_o, .ref_osc_4m_i(srcs[0]), .ring_osc_i(srcs[1]),
        .xtal_clk_i(srcs[2]), .ext_clk_in_i(srcs[3]), .pll_out_clk_i(srcs[4]),
        .pll_ref_clk_o, .pll_en_o, .pll_in_divider_o, .pll_fb_multiplier_o,
        .pll_out_divider_o, .root_clk_o, .fast_sys_clk_o, .fast_sys_clk_gated_o, .hclk_o, .aclk_o,
        .wfi_i, .irq_pending_i, .wake_rtc_i(wake[0]), .wake_wdt_i(wake[1]),
        .wake_gpio_i(wake[2]), .cpu_halt_o, .wake_irq_o);
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    // Oscillator levels as square waves; half periods in clock cycles
    int half [5] = '{6, 2, 4, 5, 3};
    int cnt [5] = '{default: 0};
    always @(posedge clk_i) begin
        for (int s = 0; s < 5; s++) begin
            if (cnt[s] == half[s] - 1) begin
                cnt[s] <= 0;
                srcs[s] <= ~srcs[s];
            end else begin
                cnt[s] <= cnt[s] + 1;
            end
        end
    end
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        hwrite_i <= wr;
        htrans_i <= 2'h2;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check(v & m, exp);
    endtask
    // Counts rising edges of one monitored clock and judges the count
    task automatic rate(input int sel, input int n, input int exp, input int tol);
        logic p;
        int   c;
        p = mon[sel];
        c = 0;
        repeat (n) begin
            @(posedge clk_i);
            if (mon[sel] === 1'b1 && p !== 1'b1) c++;
            p = mon[sel];
        end
        check(32'(c >= exp - tol && c <= exp + tol), 32'h1);
    endtask
    task automatic t_reset;
        rd(`OFS_CLK_CTRL, '1, `RST_CLK_CTRL);
        rd(`OFS_PLL_DIV, '1, `RST_PLL_DIV);
        rd(`OFS_CLK_DIV, '1, `RST_CLK_DIV);
        rd(8'h20, '1, 32'h0);
        wr(`OFS_PLL_FREQ, 32'h0);
        rd(`OFS_PLL_FREQ, '1, 32'h2710);
        check(32'({pll_in_divider_o, pll_fb_multiplier_o, pll_out_divider_o}), 32'h101);
        $display("reset test done");
    endtask
    task automatic freq1(input int i, input int f, input int o);
        int e;
        e = `REF_KHZ * (f + 2) / ((i + 2) * o * `PLL_FIXED_DIV);
        wr(`OFS_PLL_DIV, 32'((o << 14) | (f << 5) | i));
        rd(`OFS_PLL_FREQ, '1, 32'(e));
        check(32'({pll_in_divider_o, pll_fb_multiplier_o, pll_out_divider_o}),
              32'((i << 14) | (f << 5) | o));
    endtask
    task automatic t_freq;
        freq1(0, 9'h052, 5);
        freq1(1, 9'h030, 1);
        freq1(0, 9'h1ff, 1);
        freq1(31, 9'h03e, 1);
        freq1(0, 9'h03e, 16);
        freq1(0, 9'h062, 1);
        $display("frequency test done");
    endtask
    task automatic t_pll;
        wr(`OFS_CLK_CTRL, 32'h0);
        wr(`OFS_PLL_DIV, 32'h0000_4000 | (32'h062 << 5));
        wr(`OFS_CLK_CTRL, 32'h8);
        rd(`OFS_STATUS, 32'h7, 32'h0);
        rd(`OFS_STATUS, 32'h7, 32'h0);
        repeat (110) @(posedge clk_i);
        rd(`OFS_STATUS, 32'h5, 32'h1);
        wr(`OFS_CLK_CTRL, 32'hc);
        repeat (20) @(posedge clk_i);
        rd(`OFS_STATUS, 32'h5, 32'h5);
        rate(1, 120, 20, 1);
        wr(`OFS_CLK_CTRL, 32'h8);
        repeat (20) @(posedge clk_i);
        wr(`OFS_CLK_CTRL, 32'h0);
        rd(`OFS_STATUS, 32'h7, 32'h0);
        rate(1, 60, 5, 1);
        $display("pll test done");
    endtask
    task automatic t_root;
        int per [4] = '{240, 80, 160, 200};
        for (int k = 0; k < 4; k++) begin
            wr(`OFS_CLK_CTRL, 32'(k));
            repeat (30) @(posedge clk_i);
            rd(`OFS_STATUS, 32'h18, 32'(k << 3));
            rate(0, 250, 5000 / per[k], 1);
        end
        $display("root test done");
    endtask
    task automatic t_div;
        wr(`OFS_CLK_CTRL, 32'h1);
        wr(`OFS_CLK_DIV, 32'h02);
        repeat (20) @(posedge clk_i);
        rate(3, 320, 20, 1);
        rate(4, 320, 80, 1);
        wr(`OFS_CLK_DIV, 32'h10);
        repeat (20) @(posedge clk_i);
        rate(4, 320, 40, 1);
        wr(`OFS_CLK_DIV, 32'h0);
        $display("divider test done");
    endtask
    task automatic sleep_req;
        @(posedge clk_i);
        wfi_i <= 1'b1;
        @(posedge clk_i);
        wfi_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_sleep;
        int c;
        sleep_req();
        check(32'(cpu_halt_o), 32'h1);
        irq_pending_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(32'(cpu_halt_o), 32'h0);
        irq_pending_i <= 1'b0;
        wr(`OFS_CLK_CTRL, 32'h11);
        for (int k = 0; k < 3; k++) begin
            sleep_req();
            irq_pending_i <= 1'b1;
            rate(5, 60, 0, 0);
            check(32'(cpu_halt_o), 32'h1);
            wake[k] <= 1'b1;
            c = 0;
            repeat (6) begin
                @(posedge clk_i);
                if (wake_irq_o === 1'b1) c++;
            end
            wake[k] <= 1'b0;
            irq_pending_i <= 1'b0;
            check(32'(c), (k < 2) ? 32'h1 : 32'h0);
            check(32'(cpu_halt_o), 32'h0);
            rate(5, 60, 15, 1);
        end
        wr(`OFS_CLK_CTRL, 32'h0);
        $display("sleep test done");
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_freq();
        t_pll();
        t_root();
        t_div();
        t_sleep();
        end_sim();
    end
    // Whole run needs about 3000 cycles
    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
